/* shared/tofs_defs.vh */
// Register map and field layout of the thermal and overcurrent fault flag bank.
// Assumes an 8-bit register address and 8-bit data from the management interface.
`ifndef TOFS_DEFS_VH
`define TOFS_DEFS_VH

`define TOFS_ADDR_TEMP_HOT 8'hB5
`define TOFS_ADDR_OVERCURRENT 8'hB6
`define TOFS_TEMP_HOT_MASK 8'h1F
`define TOFS_OVERCURRENT_MASK 8'h07
`define TOFS_RESET_VALUE 8'h00
`define TOFS_TEMP_HOT_WIDTH 5
`define TOFS_OVERCURRENT_WIDTH 3
`define TOFS_BIT_DIE 4
`define TOFS_BIT_TERMINATION 3
`define TOFS_BIT_TOP_RIGHT 2
`define TOFS_BIT_TOP_LEFT 1
`define TOFS_BIT_BOTTOM_RIGHT 0
`define TOFS_BIT_SIXTH_CTRL 2
`define TOFS_BIT_SECOND_CTRL 1
`define TOFS_BIT_FIRST_CTRL 0

`endif

/* hdl/tofs_sync_edge.v */
// Three-stage synchroniser with rising-edge detect for asynchronous event lines.
// Assumes inputs from analog comparators outside the core_clk domain.
`timescale 1ns/1ps

module tofs_sync_edge #(
  parameter WIDTH = 5
) (
  input wire core_clk, // System clock
  input wire rst, // Async reset, active high
  input wire [WIDTH-1:0] async_in, // Raw comparator levels
  output reg [WIDTH-1:0] rise_pulse // One-cycle pulse on agreed rise
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;
  reg [WIDTH-1:0] level_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Level changes only when stages two and three agree
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
      stage3_reg <= {WIDTH{1'b0}};
      level_reg <= {WIDTH{1'b0}};
      rise_pulse <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg <= (stage2_reg & stage3_reg) | (level_reg & (stage2_reg | stage3_reg));
      rise_pulse <= (stage2_reg & stage3_reg) & ~level_reg;
    end
  end

endmodule // tofs_sync_edge

/* hdl/tofs_fault_flags.v */
// Sticky thermal-hot and overcurrent fault flags with write-one-to-clear access.
// Assumes a management-interface engine that presents decoded byte register accesses.
// Raw event lines may change at any time; they are resynchronised in here.
// Flags live only in flip-flops; no memory macro is needed.
//
// Summary of operation
// [RULE1] Die-area hot sets temperature bit 4
// [RULE2] Termination regulator hot sets bit 3
// [RULE3] Top-right corner hot sets bit 2
// [RULE4] Top-left corner hot sets bit 1
// [RULE5] Bottom-right corner hot sets bit 0
// [RULE6] Flags sticky; write one clears, zero keeps
// [RULE7] Overcurrent register at B6h, resets zero
// [RULE8] Only low-side switch overcurrent sets flags
// [RULE9] Sixth controller overcurrent sets bit 2
// [RULE10] Second controller overcurrent sets bit 1
// [RULE11] First controller overcurrent sets bit 0
// [RULE12] Five sensors each feed one hot flag
// [RULE13] Temperature register at B5h, top three zero
// [RULE14] Reserved bits read zero, writes ignored
// [RULE15] Simultaneous event and clear keeps flag set
`timescale 1ns/1ps
`include "tofs_defs.vh"

module tofs_fault_flags #(
  parameter SENSORS = `TOFS_TEMP_HOT_WIDTH,
  parameter CONTROLLERS = `TOFS_OVERCURRENT_WIDTH
) (
  input wire core_clk, // 200 MHz system clock
  input wire rst, // Async reset, active high
  input wire die_hot_raw, // Die-area sensor above hot threshold
  input wire termination_hot_raw, // Termination regulator sensor hot
  input wire top_right_hot_raw, // Top-right corner sensor hot
  input wire top_left_hot_raw, // Top-left corner sensor hot
  input wire bottom_right_hot_raw, // Bottom-right corner sensor hot
  input wire sixth_controller_oc_raw, // Sixth controller low-side switch overcurrent
  input wire second_controller_oc_raw, // Second controller low-side switch overcurrent
  input wire first_controller_oc_raw, // First controller low-side switch overcurrent
  input wire reg_wr, // Register write strobe, one cycle
  input wire reg_rd, // Register read strobe, one cycle
  input wire [7:0] reg_addr, // Register offset
  input wire [7:0] reg_wdata, // Write data
  output reg [7:0] reg_rdata, // Read data, valid cycle after reg_rd
  output reg reg_rvalid, // Read data valid pulse
  output reg [7:0] temperature_hot_status, // Live temperature flags
  output reg [7:0] overcurrent_fault_status // Live overcurrent flags
);

  wire [SENSORS-1:0] hot_raw;
  wire [CONTROLLERS-1:0] oc_raw;
  wire [SENSORS-1:0] hot_rise;
  wire [CONTROLLERS-1:0] oc_rise;
  reg [SENSORS-1:0] hot_reg;
  reg [SENSORS-1:0] hot_next;
  reg [CONTROLLERS-1:0] oc_reg;
  reg [CONTROLLERS-1:0] oc_next;
  wire hot_sel;
  wire oc_sel;
  wire hot_wr;
  wire oc_wr;
  wire [7:0] hot_clr_byte;
  wire [7:0] oc_clr_byte;
  reg [7:0] hot_calc;
  reg [7:0] oc_calc;
  reg [7:0] rdata_next;
  wire die_hot_flag;
  wire termination_regulator_hot_flag;
  wire top_right_hot_flag;
  wire top_left_hot_flag;
  wire bottom_right_hot_flag;
  wire sixth_controller_overcurrent_flag;
  wire second_controller_overcurrent_flag;
  wire first_controller_overcurrent_flag;

  // Sticky update; the set term is applied after the clear so it wins
  function [7:0] sticky_next;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      sticky_next = (cur & ~clr) | set; // [RULE6] [RULE15]
    end
  endfunction

  // Offset compare, shared by both register selects
  function addr_hits;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addr_hits = (addr == offset);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Event mapping
  assign hot_raw[`TOFS_BIT_DIE] = die_hot_raw; // [RULE1]
  assign hot_raw[`TOFS_BIT_TERMINATION] = termination_hot_raw; // [RULE2]
  assign hot_raw[`TOFS_BIT_TOP_RIGHT] = top_right_hot_raw; // [RULE3]
  assign hot_raw[`TOFS_BIT_TOP_LEFT] = top_left_hot_raw; // [RULE4]
  assign hot_raw[`TOFS_BIT_BOTTOM_RIGHT] = bottom_right_hot_raw; // [RULE5]
  // Only low-side switch detectors are wired in here
  assign oc_raw[`TOFS_BIT_SIXTH_CTRL] = sixth_controller_oc_raw; // [RULE8] [RULE9]
  assign oc_raw[`TOFS_BIT_SECOND_CTRL] = second_controller_oc_raw; // [RULE10]
  assign oc_raw[`TOFS_BIT_FIRST_CTRL] = first_controller_oc_raw; // [RULE11]

  // Separate synchronisers for sensors and controllers; a held level sets the flag once per rise
  tofs_sync_edge #(.WIDTH(SENSORS)) u_hot_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(hot_raw),
    .rise_pulse(hot_rise) // [RULE12]
  );

  tofs_sync_edge #(.WIDTH(CONTROLLERS)) u_oc_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(oc_raw),
    .rise_pulse(oc_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and flag update
  assign hot_sel = addr_hits(reg_addr, `TOFS_ADDR_TEMP_HOT); // [RULE13]
  assign oc_sel = addr_hits(reg_addr, `TOFS_ADDR_OVERCURRENT); // [RULE7]
  assign hot_wr = reg_wr & hot_sel;
  assign oc_wr = reg_wr & oc_sel;

  // Reserved positions masked off before they can reach a flag
  assign hot_clr_byte = hot_wr ? (reg_wdata & `TOFS_TEMP_HOT_MASK) : 8'h00; // [RULE14]
  assign oc_clr_byte = oc_wr ? (reg_wdata & `TOFS_OVERCURRENT_MASK) : 8'h00; // [RULE14]

  ////////////////////////////////////////////////////////////////////////////
  // Named views of the latched flags
  assign die_hot_flag = hot_reg[`TOFS_BIT_DIE];
  assign termination_regulator_hot_flag = hot_reg[`TOFS_BIT_TERMINATION];
  assign top_right_hot_flag = hot_reg[`TOFS_BIT_TOP_RIGHT];
  assign top_left_hot_flag = hot_reg[`TOFS_BIT_TOP_LEFT];
  assign bottom_right_hot_flag = hot_reg[`TOFS_BIT_BOTTOM_RIGHT];
  assign sixth_controller_overcurrent_flag = oc_reg[`TOFS_BIT_SIXTH_CTRL];
  assign second_controller_overcurrent_flag = oc_reg[`TOFS_BIT_SECOND_CTRL];
  assign first_controller_overcurrent_flag = oc_reg[`TOFS_BIT_FIRST_CTRL];

  ////////////////////////////////////////////////////////////////////////////
  // Next flag values; a zero clear mask leaves plain accumulation
  always @* begin
    hot_calc = sticky_next({3'h0, hot_reg}, {3'h0, hot_rise}, hot_clr_byte); // [RULE6] [RULE15]
    hot_next = hot_calc[SENSORS-1:0];
  end

  always @* begin
    oc_calc = sticky_next({5'h00, oc_reg}, {5'h00, oc_rise}, oc_clr_byte); // [RULE6] [RULE15]
    oc_next = oc_calc[CONTROLLERS-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; a read in the cycle of a clear returns the old value
  always @* begin
    rdata_next = 8'h00;
    case ({hot_sel, oc_sel})
      2'b10: begin
        rdata_next = {3'h0, die_hot_flag, termination_regulator_hot_flag, top_right_hot_flag,
                      top_left_hot_flag, bottom_right_hot_flag}; // [RULE13]
      end
      2'b01: begin
        rdata_next = {5'h00, sixth_controller_overcurrent_flag,
                      second_controller_overcurrent_flag,
                      first_controller_overcurrent_flag}; // [RULE7]
      end
      default: begin
        // Other offsets belong to neighbouring banks; read zero here
        rdata_next = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag storage
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hot_reg <= {SENSORS{1'b0}};
      oc_reg <= {CONTROLLERS{1'b0}}; // [RULE7]
    end else begin
      hot_reg <= hot_next;
      oc_reg <= oc_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status mirrors, registered so the pins never glitch
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      temperature_hot_status <= `TOFS_RESET_VALUE;
      overcurrent_fault_status <= `TOFS_RESET_VALUE;
    end else begin
      temperature_hot_status <= {3'h0, hot_next}; // [RULE13]
      overcurrent_fault_status <= {5'h00, oc_next}; // [RULE14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; data holds until the next read
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `TOFS_RESET_VALUE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

endmodule // tofs_fault_flags

/* verification/tofs_fault_flags_properties.sv */
// Port-level checks for the fault flag bank.
// Assumes bind onto tofs_fault_flags, one core_clk domain.
`timescale 1ns/1ps
module tofs_fault_flags_props (
  input wire core_clk, // Clock
  input wire rst, // Reset
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [7:0] reg_addr, // Offset
  input wire [7:0] reg_wdata, // Write data
  input wire [7:0] reg_rdata, // Read data
  input wire reg_rvalid, // Read valid
  input wire die_hot_raw, // Die sensor
  input wire first_controller_oc_raw, // First controller
  input wire [7:0] temperature_hot_status, // Temp flags
  input wire [7:0] overcurrent_fault_status // Overcurrent flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire clr0 = reg_wr && reg_addr == 8'hB6 && reg_wdata[0];
  wire unm = reg_addr != 8'hB5 && reg_addr != 8'hB6;
  property p_rv; reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read valid missing");
  property p_nrv; !reg_rd |=> !reg_rvalid; endproperty
  a_nrv: assert property (p_nrv) else $error("stray read valid");
  property p_tres; temperature_hot_status[7:5] == 3'h0; endproperty
  a_tres: assert property (p_tres) else $error("temp reserved set");
  property p_ores; overcurrent_fault_status[7:3] == 5'h00; endproperty
  a_ores: assert property (p_ores) else $error("oc reserved set");
  property p_trd; reg_rd && reg_addr == 8'hB5 |=> reg_rdata == $past(temperature_hot_status); endproperty
  a_trd: assert property (p_trd) else $error("temp read wrong");
  property p_ord; reg_rd && reg_addr == 8'hB6 |=> reg_rdata == $past(overcurrent_fault_status); endproperty
  a_ord: assert property (p_ord) else $error("oc read wrong");
  property p_unm; reg_rd && unm |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
  property p_keep; overcurrent_fault_status[0] && !clr0 |=> overcurrent_fault_status[0]; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
  property p_clr; (!first_controller_oc_raw)[*6] ##0 clr0 |=> !overcurrent_fault_status[0]; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_set; $rose(die_hot_raw) ##0 die_hot_raw[*6] |=> temperature_hot_status[4]; endproperty
  a_set: assert property (p_set) else $error("die hot not latched");
  c_clr: cover property (clr0);
  c_unm: cover property (reg_rd && unm);
  c_set: cover property ($rose(temperature_hot_status[4]));
endmodule // tofs_fault_flags_props
bind tofs_fault_flags tofs_fault_flags_props u_props (.*);

/* verification/tofs_host_model.sv */
// Host model issuing single-byte register accesses.
// Assumes strobes sampled at posedge; drives at falling edge.
`timescale 1ns/1ps
module tofs_host_model (
  input wire core_clk, // Clock
  input wire [7:0] reg_rdata, // Read data
  input wire reg_rvalid, // Read valid
  output logic reg_wr = 1'b0, // Write strobe
  output logic reg_rd = 1'b0, // Read strobe
  output logic [7:0] reg_addr = 8'h00, // Offset
  output logic [7:0] reg_wdata = 8'h00 // Write data
);
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge core_clk);
    // Idle bus shows no stale value
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge core_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge core_clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    {d, v} = {reg_rdata, reg_rvalid};
  endtask
endmodule // tofs_host_model

/* verification/thermal_overcurrent_fault_flags_bench.sv */
// Self-checking bench for the fault flag bank.
// Assumes the host model drives the register strobes.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module thermal_overcurrent_fault_flags_bench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic v;
  logic [7:0] ev = 8'h00, rdata, exp_t = 8'h00, exp_o = 8'h00;
  wire [7:0] reg_rdata, reg_addr, reg_wdata, temperature_hot_status, overcurrent_fault_status;
  wire reg_rvalid, reg_wr, reg_rd;
  int n_errors = 0, comparisons = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  tofs_fault_flags u_tofs_fault_flags (.*, .die_hot_raw(ev[4]), .termination_hot_raw(ev[3]),
    .top_right_hot_raw(ev[2]), .top_left_hot_raw(ev[1]), .bottom_right_hot_raw(ev[0]),
    .sixth_controller_oc_raw(ev[7]), .second_controller_oc_raw(ev[6]),
    .first_controller_oc_raw(ev[5]));
  tofs_host_model host (.*);
  task rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rdata, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, rdata)
  endtask
  task report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    rdc(8'hB5, 8'h00);
    rdc(8'hB6, 8'h00);
    // One source at a time, so a mismapped bit shows
    for (int i = 0; i < 8; i++) begin
      @(negedge core_clk) ev[i] = 1'b1;
      repeat (6) @(negedge core_clk);
      ev[i] = 1'b0;
      if (i < 5) exp_t[i] = 1'b1;
      else exp_o[i-5] = 1'b1;
      rdc(8'hB5, exp_t);
      rdc(8'hB6, exp_o);
    end
    host.wr(8'hB5, 8'hE1);
    rdc(8'hB5, 8'h1E);
    host.wr(8'hB5, 8'h00);
    rdc(8'hB5, 8'h1E);
    host.wr(8'hB7, 8'hFF);
    rdc(8'hB7, 8'h00);
    rdc(8'hB5, 8'h1E);
    host.wr(8'hB6, 8'hFF);
    rdc(8'hB6, 8'h00);
    `CHK("overcurrent_fault_status", 8'h00, overcurrent_fault_status)
    // Clear lands on the edge of the new set
    @(negedge core_clk) ev[5] = 1'b1;
    repeat (3) @(negedge core_clk);
    host.wr(8'hB6, 8'h01);
    rdc(8'hB6, 8'h01);
    ev[5] = 1'b0;
    host.wr(8'hB6, 8'h01);
    rdc(8'hB6, 8'h00);
    @(negedge core_clk) rst = 1'b1;
    @(negedge core_clk) rst = 1'b0;
    `CHK("temp status", 8'h00, temperature_hot_status)
    rdc(8'hB5, 8'h00);
    report_and_stop();
  end
endmodule // thermal_overcurrent_fault_flags_bench
